// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int LIMIT = 60000;
    logic       mclk;
    logic       lclk;
    logic       rst;
    logic [7:0] rd_data;
    logic       scl;
    logic       pull;
    logic       sda_oe;
    logic       sda_out;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] reg_addr;
    logic [7:0] wr_data;
    wire logic  sda;
    logic [7:0] regs [256];
    logic [7:0] expv [256];
    int         n_errors = 0;
    int         compares = 0;
    int         cycles = 0;

    assign sda = (pull | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;

    twrt_target dut (.I_MCLK(mclk), .I_RST(rst), .I_LCLK(lclk), .I_SCL(scl), .I_SDA(sda),
        .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .O_WR_STB(wr_stb), .O_RD_STB(rd_stb),
        .O_REG_ADDR(reg_addr), .O_WR_DATA(wr_data), .I_RD_DATA(rd_data));

    twrt_ctrl_model m_ctrl (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial
    begin
        lclk = 1'b0;
        #3.7;
        forever #6 lclk = ~lclk;
    end

    // register file; read data scrambled except the cycle after a read
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (wr_stb === 1'b1)
            regs[reg_addr] <= wr_data;
        rd_data <= (rd_stb === 1'b1) ? regs[reg_addr] : ~rd_data;
        if (cycles == LIMIT)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic send(input logic [7:0] d, input logic ack_exp);
        logic a;
        m_ctrl.wr_byte(d, a);
        check("ack", {7'h00, a}, {7'h00, ack_exp});
    endtask : send

    task automatic recv(input logic mack, input logic [7:0] exp);
        logic [7:0] d;
        m_ctrl.rd_byte(mack, d);
        check("rdata", d, exp);
    endtask : recv

    task automatic t_write_seq;
        m_ctrl.start();
        send(8'hC4, 1'b1);
        send(8'h10, 1'b1);
        send(8'hA1, 1'b1);
        send(8'hB2, 1'b1);
        m_ctrl.stop();
        expv[8'h10] = 8'hA1;
        expv[8'h11] = 8'hB2;
        check("reg10", regs[8'h10], expv[8'h10]);
        check("reg11", regs[8'h11], expv[8'h11]);
        check("reg12", regs[8'h12], expv[8'h12]);
    endtask : t_write_seq

    task automatic t_preset_read;
        m_ctrl.start();
        send(8'hC4, 1'b1);
        send(8'h10, 1'b1);
        m_ctrl.start();
        send(8'hC5, 1'b1);
        recv(1'b1, expv[8'h10]);
        recv(1'b1, expv[8'h11]);
        recv(1'b0, expv[8'h12]);
        m_ctrl.stop();
    endtask : t_preset_read

    task automatic t_read_zero;
        m_ctrl.start();
        send(8'hC5, 1'b1);
        recv(1'b1, expv[8'h00]);
        recv(1'b0, expv[8'h01]);
        m_ctrl.stop();
        m_ctrl.start();
        send(8'hC5, 1'b1);
        recv(1'b0, expv[8'h00]);
        m_ctrl.stop();
    endtask : t_read_zero

    task automatic t_fifo;
        m_ctrl.start();
        send(8'hC4, 1'b1);
        send(8'h07, 1'b1);
        send(8'h11, 1'b1);
        send(8'h22, 1'b1);
        m_ctrl.stop();
        check("fifo", regs[8'h07], 8'h22);
        check("after fifo", regs[8'h08], expv[8'h08]);
        m_ctrl.start();
        send(8'hC4, 1'b1);
        send(8'h07, 1'b1);
        m_ctrl.start();
        send(8'hC5, 1'b1);
        recv(1'b1, 8'h22);
        recv(1'b0, 8'h22);
        m_ctrl.stop();
    endtask : t_fifo

    task automatic t_bad_addr;
        logic [7:0] bad [4] = '{8'hC6, 8'h44, 8'hE4, 8'hC7};
        foreach (bad[i])
        begin
            m_ctrl.start();
            send(bad[i], 1'b0);
            send(8'h05, 1'b0);
            send(8'h99, 1'b0);
            m_ctrl.stop();
        end
        check("reg05", regs[8'h05], expv[8'h05]);
    endtask : t_bad_addr

    task automatic t_early_stop;
        logic r;
        logic f;
        m_ctrl.start();
        send(8'hC4, 1'b1);
        send(8'h20, 1'b1);
        m_ctrl.bit_io(1'b1, r, f);
        m_ctrl.bit_io(1'b0, r, f);
        m_ctrl.bit_io(1'b1, r, f);
        m_ctrl.stop();
        m_ctrl.start();
        send(8'hC4, 1'b1);
        send(8'h21, 1'b1);
        send(8'h77, 1'b1);
        m_ctrl.stop();
        check("reg20", regs[8'h20], expv[8'h20]);
        check("reg21", regs[8'h21], 8'h77);
    endtask : t_early_stop

    task automatic finish_test;
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        rst = 1'b1;
        rd_data = 8'h00;
        for (int i = 0; i < 256; i++)
        begin
            regs[i] = 8'(i) ^ 8'h3C;
            expv[i] = 8'(i) ^ 8'h3C;
        end
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_write_seq();
        t_preset_read();
        t_read_zero();
        t_fifo();
        t_bad_addr();
        t_early_stop();
        finish_test();
    end
endmodule : tb

`default_nettype wire

// ---- testbench/twrt_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module twrt_ctrl_model (
    output var  logic o_scl,       // serial clock, driven only here
    output var  logic o_sda_pull,  // high pulls the data line low
    input  wire logic i_sda        // resolved data line
);
    localparam time QTR = 625ns;

    initial
    begin
        o_scl      = 1'b1;
        o_sda_pull = 1'b0;
    end

    task automatic bit_io(input logic drv, output logic s_rise, output logic s_fall);
        #QTR;
        o_sda_pull = ~drv;
        #QTR;
        o_scl = 1'b1;
        s_rise = i_sda;
        #(2*QTR);
        s_fall = i_sda;
        o_scl = 1'b0;
    endtask : bit_io

    task automatic start;
        #QTR;
        o_sda_pull = 1'b0;
        #QTR;
        o_scl = 1'b1;
        #QTR;
        o_sda_pull = 1'b1;
        #QTR;
        o_scl = 1'b0;
    endtask : start

    task automatic stop;
        #QTR;
        o_sda_pull = 1'b1;
        #QTR;
        o_scl = 1'b1;
        #QTR;
        o_sda_pull = 1'b0;
        #QTR;
    endtask : stop

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        logic f;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r, f);
        bit_io(1'b1, r, f);
        ack = ~r & ~f;
    endtask : wr_byte

    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic r;
        logic f;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r, f);
            d[i] = (r === f) ? r : 1'bx;
        end
        bit_io(~mack, r, f);
    endtask : rd_byte
endmodule : twrt_ctrl_model

`default_nettype wire

// ---- verilog/twrt_map.svh ----
`ifndef TWRT_MAP_SVH
`define TWRT_MAP_SVH

// 7-bit target address, write byte 8'hC4 and read byte 8'hC5
`define TWRT_TARGET_ADDR 7'h62
// pointer value of the FIFO data register (no auto-increment there)
`define TWRT_FIFO_PTR 8'h07
// pointer after a plain START and read
`define TWRT_PTR_RESET 8'h00
// bits per byte before the acknowledge pulse
`define TWRT_BYTE_BITS 4'h8
// byte shifted out when register data is not back in time
`define TWRT_IDLE_BYTE 8'hFF

`endif

// ---- verilog/twrt_pkg.sv ----
package twrt_pkg;

    typedef enum logic [2:0] {
        TWRT_IDLE,
        TWRT_ADDR,
        TWRT_RX,
        TWRT_ACK,
        TWRT_TX,
        TWRT_MACK
    } twrt_state_type;

    // everything clocked by the link clock
    typedef struct packed {
        twrt_state_type st;
        logic [3:0]     bitcnt;
        logic [7:0]     shreg;
        logic [7:0]     ptr;
        logic           need_ptr;
        logic           ptr_valid;
        logic           rw;
        logic           mnack;
        logic           start_hi;
        logic           sda_oe;
        logic           sda_out;
        logic           scl_s1;
        logic           scl_s2;
        logic           scl_q;
        logic           sda_s1;
        logic           sda_s2;
        logic           sda_q;
        logic           ack_s1;
        logic           ack_s2;
        logic           req_tgl;
        logic           req_rd;
        logic [7:0]     req_addr;
        logic [7:0]     req_data;
    } twrt_link_type;

    // everything clocked by I_MCLK
    typedef struct packed {
        logic       req_s1;
        logic       req_s2;
        logic       req_s3;
        logic       wr_stb;
        logic       rd_stb;
        logic       cap;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic       ack_tgl;
    } twrt_host_type;

endpackage : twrt_pkg

// ---- verilog/twrt_target.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "twrt_map.svh"

module twrt_target (
    input  wire logic       I_MCLK,      // register-side clock
    input  wire logic       I_RST,       // async reset, active high
    input  wire logic       I_LCLK,      // link oversampling clock
    input  wire logic       I_SCL,       // serial clock pin
    input  wire logic       I_SDA,       // serial data pin level
    output var  logic       O_SDA_OUT,   // data pin drive value
    output var  logic       O_SDA_OE,    // data pin pulled low when high
    output var  logic       O_WR_STB,    // register write pulse
    output var  logic       O_RD_STB,    // register read pulse
    output var  logic [7:0] O_REG_ADDR,  // register pointer of the access
    output var  logic [7:0] O_WR_DATA,   // write data
    input  wire logic [7:0] I_RD_DATA    // read data, cycle after O_RD_STB
);

    twrt_pkg::twrt_link_type r;
    twrt_pkg::twrt_link_type next_r;
    twrt_pkg::twrt_host_type h;
    twrt_pkg::twrt_host_type next_h;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic addr_hit;
    logic rd_ready;

    function automatic logic [7:0] twrt_adv(input logic [7:0] p);
        if (p == `TWRT_FIFO_PTR)
            return p;
        return 8'(p + 8'h01);
    endfunction : twrt_adv

    assign scl_rise  = r.scl_s2 && !r.scl_q;
    assign scl_fall  = !r.scl_s2 && r.scl_q;
    // edge of data while clock high
    assign bus_start = r.scl_s2 && r.scl_q && r.sda_q && !r.sda_s2;
    assign bus_stop  = r.scl_s2 && r.scl_q && !r.sda_q && r.sda_s2;
    assign addr_hit  = (r.shreg[7:1] == `TWRT_TARGET_ADDR);
    assign rd_ready  = (r.ack_s2 == r.req_tgl);

    always_comb
    begin
        logic [7:0] rd;
        rd = rd_ready ? h.rdata : `TWRT_IDLE_BYTE;
        next_r = r;
        next_r.scl_s1 = I_SCL;
        next_r.scl_s2 = r.scl_s1;
        next_r.scl_q  = r.scl_s2;
        next_r.sda_s1 = I_SDA;
        next_r.sda_s2 = r.sda_s1;
        next_r.sda_q  = r.sda_s2;
        next_r.ack_s1 = h.ack_tgl;
        next_r.ack_s2 = r.ack_s1;
        if (scl_fall)
            next_r.start_hi = 1'b0;
        if (bus_start)
        begin
            next_r.st       = twrt_pkg::TWRT_ADDR;
            next_r.bitcnt   = 4'h0;
            next_r.sda_oe   = 1'b0;
            next_r.start_hi = 1'b1;
        end
        else if (bus_stop && !r.start_hi)
        begin
            next_r.st        = twrt_pkg::TWRT_IDLE;
            next_r.sda_oe    = 1'b0;
            next_r.need_ptr  = 1'b0;
            next_r.ptr_valid = 1'b0;
        end
        else
        begin
            case (r.st)
                twrt_pkg::TWRT_IDLE:
                begin
                    next_r.sda_oe = 1'b0;
                end
                twrt_pkg::TWRT_ADDR, twrt_pkg::TWRT_RX:
                begin
                    if (scl_rise)
                    begin
                        next_r.shreg  = {r.shreg[6:0], r.sda_s2};
                        next_r.bitcnt = 4'(r.bitcnt + 4'h1);
                    end
                    else if (scl_fall && r.bitcnt == `TWRT_BYTE_BITS)
                    begin
                        if (r.st == twrt_pkg::TWRT_ADDR && !addr_hit)
                        begin
                            next_r.st = twrt_pkg::TWRT_IDLE;
                        end
                        else
                        begin
                            next_r.st     = twrt_pkg::TWRT_ACK;
                            next_r.sda_oe = 1'b1;
                            if (r.st == twrt_pkg::TWRT_ADDR)
                            begin
                                next_r.rw = r.shreg[0];
                                if (r.shreg[0])
                                begin
                                    if (!r.ptr_valid)
                                        next_r.ptr = `TWRT_PTR_RESET;
                                    next_r.req_tgl  = ~r.req_tgl;
                                    next_r.req_rd   = 1'b1;
                                    next_r.req_addr = next_r.ptr;
                                end
                                else
                                    next_r.need_ptr = 1'b1;
                            end
                            else if (r.need_ptr)
                            begin
                                next_r.ptr       = r.shreg;
                                next_r.need_ptr  = 1'b0;
                                next_r.ptr_valid = 1'b1;
                            end
                            else
                            begin
                                next_r.req_tgl  = ~r.req_tgl;
                                next_r.req_rd   = 1'b0;
                                next_r.req_addr = r.ptr;
                                next_r.req_data = r.shreg;
                                next_r.ptr      = twrt_adv(r.ptr);
                            end
                        end
                    end
                end
                twrt_pkg::TWRT_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_r.bitcnt = 4'h0;
                        if (r.rw)
                        begin
                            next_r.st     = twrt_pkg::TWRT_TX;
                            next_r.sda_oe = !rd[7];
                            next_r.shreg  = {rd[6:0], 1'b0};
                            next_r.bitcnt = 4'h1;
                        end
                        else
                        begin
                            next_r.st     = twrt_pkg::TWRT_RX;
                            next_r.sda_oe = 1'b0;
                        end
                    end
                end
                twrt_pkg::TWRT_TX:
                begin
                    if (scl_fall)
                    begin
                        if (r.bitcnt == `TWRT_BYTE_BITS)
                        begin
                            next_r.st       = twrt_pkg::TWRT_MACK;
                            next_r.sda_oe   = 1'b0;
                            next_r.ptr      = twrt_adv(r.ptr);
                            next_r.req_tgl  = ~r.req_tgl;
                            next_r.req_rd   = 1'b1;
                            next_r.req_addr = twrt_adv(r.ptr);
                        end
                        else
                        begin
                            next_r.sda_oe = !r.shreg[7];
                            next_r.shreg  = {r.shreg[6:0], 1'b0};
                            next_r.bitcnt = 4'(r.bitcnt + 4'h1);
                        end
                    end
                end
                twrt_pkg::TWRT_MACK:
                begin
                    if (scl_rise)
                        next_r.mnack = r.sda_s2;
                    else if (scl_fall)
                    begin
                        if (r.mnack)
                            next_r.st = twrt_pkg::TWRT_IDLE;
                        else
                        begin
                            next_r.st     = twrt_pkg::TWRT_TX;
                            next_r.sda_oe = !rd[7];
                            next_r.shreg  = {rd[6:0], 1'b0};
                            next_r.bitcnt = 4'h1;
                        end
                    end
                end
                default:
                begin
                    next_r.st     = twrt_pkg::TWRT_IDLE;
                    next_r.sda_oe = 1'b0;
                end
            endcase
        end
        next_r.sda_out = 1'b0;
    end

    always_ff @(posedge I_LCLK or posedge I_RST)
    begin
        if (I_RST)
            r <= '0;
        else
            r <= next_r;
    end

    // register side: toggle request in, toggle answer back
    always_comb
    begin
        next_h        = h;
        next_h.req_s1 = r.req_tgl;
        next_h.req_s2 = h.req_s1;
        next_h.req_s3 = h.req_s2;
        next_h.wr_stb = 1'b0;
        next_h.rd_stb = 1'b0;
        if (h.cap)
        begin
            // read data is valid one cycle after the strobe
            if (!h.rd_stb)
            begin
                next_h.rdata   = I_RD_DATA;
                next_h.cap     = 1'b0;
                next_h.ack_tgl = ~h.ack_tgl;
            end
        end
        else if (h.req_s2 != h.req_s3)
        begin
            next_h.addr  = r.req_addr;
            next_h.wdata = r.req_data;
            if (r.req_rd)
            begin
                next_h.rd_stb = 1'b1;
                next_h.cap    = 1'b1;
            end
            else
            begin
                next_h.wr_stb  = 1'b1;
                next_h.ack_tgl = ~h.ack_tgl;
            end
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
            h <= '0;
        else
            h <= next_h;
    end

    assign O_SDA_OUT  = r.sda_out;
    assign O_SDA_OE   = r.sda_oe;
    assign O_WR_STB   = h.wr_stb;
    assign O_RD_STB   = h.rd_stb;
    assign O_REG_ADDR = h.addr;
    assign O_WR_DATA  = h.wdata;

    chk_sda_low_only: assert property (@(posedge I_LCLK) disable iff (I_RST)
        !O_SDA_OUT) else $error("data pin driven high");

    chk_start_to_addr: assert property (@(posedge I_LCLK) disable iff (I_RST)
        bus_start |=> r.st == twrt_pkg::TWRT_ADDR && !O_SDA_OE) else $error("start not taken");

    chk_stop_to_idle: assert property (@(posedge I_LCLK) disable iff (I_RST)
        bus_stop && !bus_start && !r.start_hi |=> r.st == twrt_pkg::TWRT_IDLE && !r.ptr_valid)
        else $error("stop not honoured");

    chk_addr_ack: assert property (@(posedge I_LCLK) disable iff (I_RST)
        r.st == twrt_pkg::TWRT_ADDR && scl_fall && r.bitcnt == 4'h8 && addr_hit && !bus_start && !bus_stop
        |=> O_SDA_OE && r.st == twrt_pkg::TWRT_ACK) else $error("address not acknowledged");

    chk_ack_held: assert property (@(posedge I_LCLK) disable iff (I_RST)
        r.st == twrt_pkg::TWRT_ACK && !scl_fall && !bus_start && !bus_stop
        |=> O_SDA_OE && r.st == twrt_pkg::TWRT_ACK) else $error("ack not held");

    chk_foreign_release: assert property (@(posedge I_LCLK) disable iff (I_RST)
        r.st == twrt_pkg::TWRT_ADDR && scl_fall && r.bitcnt == 4'h8 && !addr_hit && !bus_start && !bus_stop
        |=> !O_SDA_OE && r.st == twrt_pkg::TWRT_IDLE) else $error("foreign address answered");

    chk_read_ptr_zero: assert property (@(posedge I_LCLK) disable iff (I_RST)
        r.st == twrt_pkg::TWRT_ADDR && scl_fall && r.bitcnt == 4'h8 && addr_hit && r.shreg[0]
        && !r.ptr_valid && !bus_start && !bus_stop |=> r.ptr == 8'h00 && r.req_rd)
        else $error("read pointer not zeroed");

    chk_oe_stable_high: assert property (@(posedge I_LCLK) disable iff (I_RST)
        r.scl_s2 && r.scl_q && r.st != twrt_pkg::TWRT_IDLE |-> O_SDA_OE == $past(O_SDA_OE))
        else $error("data changed while clock high");

    chk_write_advance: assert property (@(posedge I_LCLK) disable iff (I_RST)
        r.st == twrt_pkg::TWRT_RX && scl_fall && r.bitcnt == 4'h8 && !r.need_ptr && !bus_start && !bus_stop
        |=> r.req_addr == $past(r.ptr)
        && r.ptr == (($past(r.ptr) == `TWRT_FIFO_PTR) ? $past(r.ptr) : 8'($past(r.ptr) + 8'h01)))
        else $error("write pointer wrong");

    chk_fifo_hold: assert property (@(posedge I_LCLK) disable iff (I_RST)
        r.st == twrt_pkg::TWRT_TX && scl_fall && r.bitcnt == 4'h8 && r.ptr == `TWRT_FIFO_PTR
        && !bus_start && !bus_stop |=> r.ptr == `TWRT_FIFO_PTR) else $error("fifo pointer moved");

    chk_read_capture: assert property (@(posedge I_MCLK) disable iff (I_RST)
        O_RD_STB |-> ##2 (h.rdata == $past(I_RD_DATA) && h.ack_tgl != $past(h.ack_tgl)))
        else $error("read data not captured");

    cov_write_byte: cover property (@(posedge I_MCLK) disable iff (I_RST) O_WR_STB);
    cov_read_byte: cover property (@(posedge I_LCLK) disable iff (I_RST)
        r.st == twrt_pkg::TWRT_TX ##[1:1000] r.st == twrt_pkg::TWRT_MACK);
    cov_master_nack: cover property (@(posedge I_LCLK) disable iff (I_RST)
        r.st == twrt_pkg::TWRT_MACK && r.mnack && scl_fall);
    cov_repeated_start: cover property (@(posedge I_LCLK) disable iff (I_RST) bus_start && r.ptr_valid);

endmodule : twrt_target
`default_nettype wire
